// ---- design/ptc_timer.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - auto-start: start on every transmission end
// - auto-start: start on field-on with inversion
// - five-bit modes: stop after fifth bit
// - other modes: stop after fourth bit
// - multi-frame: no auto stop, software stops
// - auto-start off: protocol events ignored, even divide select still applies
// - gate field picks none, serial, aux
// - active flag ignores gate level
// - reload-on-zero restarts from reload value
// - otherwise stop at zero, raise expiry
// - prescaler is nibble plus low byte
// - odd divide: 2P+1 carrier periods
// - even divide: 2P+2 carrier periods
// - reload value sampled only at start
module ptc_timer
  import ptc_pkg::*;
(
  input  wire logic              sys_clk,               // 20 MHz system clock
  input  wire logic              rstn,                  // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr,                  // Register address
  input  wire logic [DATA_W-1:0] wr_data,               // Register write data
  input  wire logic              wr_en,                 // Write strobe
  input  wire logic              rd_en,                 // Read strobe
  output logic      [DATA_W-1:0] rd_data,               // Read data, cycle after rd_en
  input  wire logic              carrier_tick,          // One pulse per 13.56 MHz period
  input  wire ptc_proto_t        proto,                 // Protocol events and modes
  input  wire logic              secure_serial_in_pin,  // Gate pin, asynchronous
  input  wire logic              auxiliary_pin_one,     // Gate pin, asynchronous
  output logic                   timer_active_flag,     // Timer enabled
  output logic                   irq                    // Level interrupt
);

  // ************************************************************
  // Gate pin synchronisers
  // ************************************************************
  logic [NUM_GATES-1:0] pin_raw;
  logic [NUM_GATES-1:0] sync1_q;
  logic [NUM_GATES-1:0] sync2_q;
  logic [NUM_GATES-1:0] sync3_q;
  logic [NUM_GATES-1:0] gate_q;
  logic [NUM_GATES-1:0] gate_d;

  // Stage one may go metastable; only the last two stages vote
  // Pins read as low after reset, so a gated timer starts closed
  assign pin_raw = {auxiliary_pin_one, secure_serial_in_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GATES; gi++) begin : g_sync
      // Level is accepted only once two late stages agree
      always_comb begin
        gate_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : gate_q[gi];
      end
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          gate_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          gate_q[gi]  <= gate_d[gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Software registers
  // ************************************************************
  logic [7:0]  tmode_q,   tmode_d;
  logic [7:0]  tpsc_q,    tpsc_d;
  logic [15:0] reload_q,  reload_d;
  logic        expired_q, expired_d;
  logic        mask_q,    mask_d;
  logic        sw_start,  sw_stop;
  logic        expire_evt;

  // Exact byte compare, shared by the write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  always_comb begin
    tmode_d   = tmode_q;
    tpsc_d    = tpsc_q;
    reload_d  = reload_q;
    mask_d    = mask_q;
    expired_d = expired_q;
    sw_start  = 1'b0;
    sw_stop   = 1'b0;
    if (wr_en) begin
      // Count bytes are read only; strobes to unmapped addresses are dropped
      if (hit(addr, ADDR_TMODE))     tmode_d        = wr_data;
      if (hit(addr, ADDR_TPRESCALE)) tpsc_d         = wr_data;
      if (hit(addr, ADDR_RELOAD_HI)) reload_d[15:8] = wr_data;
      if (hit(addr, ADDR_RELOAD_LO)) reload_d[7:0]  = wr_data;
      if (hit(addr, ADDR_IRQ_MASK))  mask_d         = wr_data[BIT_EXPIRED];
      if (hit(addr, ADDR_IRQ_STAT) && wr_data[BIT_EXPIRED]) begin
        expired_d = 1'b0;
      end
      // Control bits are one-cycle pulses; nothing is stored, so 43h reads 00
      if (hit(addr, ADDR_CONTROL)) begin
        sw_start = wr_data[BIT_START_NOW];
        sw_stop  = wr_data[BIT_STOP_NOW];
      end
    end
    // Expiry is flagged in reload mode too, so software can count periods
    // A new expiry beats a clear in the same cycle
    if (expire_evt) begin
      expired_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tmode_q   <= RESET_BYTE;
      tpsc_q    <= RESET_BYTE;
      reload_q  <= {RESET_BYTE, RESET_BYTE};
      mask_q    <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      tmode_q   <= tmode_d;
      tpsc_q    <= tpsc_d;
      reload_q  <= reload_d;
      mask_q    <= mask_d;
      expired_q <= expired_d;
    end
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  logic             auto_start_enable;
  logic             reload_on_zero;
  ptc_gate_t        gate_source_select;
  logic [PSC_W-1:0] prescale;
  logic [DIV_W-1:0] div_limit;
  logic             gate_open;

  assign auto_start_enable  = tmode_q[BIT_AUTO];
  assign reload_on_zero     = tmode_q[BIT_RELOAD];
  assign gate_source_select = ptc_gate_t'(tmode_q[GATE_HI:GATE_LO]);
  assign prescale           = {tmode_q[PSC_HI_MSB:0], tpsc_q};
  // Divider wraps after limit+1 carrier periods
  // Even divide adds one carrier period to the odd divide
  // Prescaler fields are read live and act on the divider period in progress
  assign div_limit = proto.even_prescale_select
                   ? {prescale, 1'b0} + DIV_ONE
                   : {prescale, 1'b0};

  always_comb begin
    unique case (gate_source_select)
      GATE_NONE: gate_open = 1'b1;
      GATE_SSI:  gate_open = gate_q[0];
      GATE_AUXILIARY_PIN_ONE: gate_open = gate_q[1];
      GATE_RSVD: gate_open = 1'b0;  // Undefined code holds the count
    endcase
  end

  // ************************************************************
  // Timer core
  // ************************************************************
  ptc_state_t       state_q, state_d;
  logic [CNT_W-1:0] cnt_q,   cnt_d;
  logic [DIV_W-1:0] div_q,   div_d;
  logic [RXB_W-1:0] rxb_q,   rxb_d;
  // Reload value captured at start; auto-restart reuses it
  logic [CNT_W-1:0] start_val_q, start_val_d;
  logic             auto_start;
  logic             auto_stop;
  logic [RXB_W-1:0] stop_bits;
  logic             tick;

  always_comb begin
    // Protocol events only count with auto-start set
    auto_start = auto_start_enable &&
                 (proto.tx_end ||
                  (proto.inverted_tx_field_on && proto.rf_field_on));
    stop_bits  = proto.five_bit_mode ? STOP_BITS_LONG
                                     : STOP_BITS_SHORT;
    auto_stop  = auto_start_enable && !proto.multi_frame_receive &&
                 (state_q == ST_RUN) && proto.rx_bit &&
                 (rxb_q + 3'h1 == stop_bits);
    // Greater-or-equal keeps a lowered prescaler from letting the divider wrap
    tick       = (state_q == ST_RUN) && gate_open && carrier_tick &&
                 (div_q >= div_limit);
  end

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    div_d      = div_q;
    rxb_d      = rxb_q;
    start_val_d = start_val_q;
    expire_evt = 1'b0;
    // Start outranks stop, so a start in a stop cycle keeps the timer running
    if (auto_start || sw_start) begin
      state_d     = ST_RUN;
      cnt_d       = reload_q;
      start_val_d = reload_q;
      div_d       = DIV_ZERO;
      rxb_d       = '0;
    end else if (auto_stop || sw_stop) begin
      // Stop freezes the count so software can read the time left
      state_d = ST_IDLE;
    end else if (state_q == ST_RUN) begin
      // Bit counter clears only at start and may wrap in multi-frame mode
      if (proto.rx_bit) begin
        rxb_d = rxb_q + 3'h1;
      end
      // A closed gate freezes the divider mid-period instead of restarting it
      if (gate_open && carrier_tick) begin
        div_d = tick ? DIV_ZERO : div_q + DIV_ONE;
      end
      if (tick) begin
        // A reload of zero expires at the first tick
        if (cnt_q == CNT_ZERO || cnt_q == CNT_ONE) begin
          expire_evt = 1'b1;
          if (reload_on_zero) begin
            // Captured value, so a reload written mid-run waits for a start
            cnt_d = start_val_q;
          end else begin
            cnt_d   = CNT_ZERO;
            state_d = ST_IDLE;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
      div_q   <= DIV_ZERO;
      rxb_q   <= '0;
      start_val_q <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      div_q   <= div_d;
      rxb_q   <= rxb_d;
      start_val_q <= start_val_d;
    end
  end

  // ************************************************************
  // Read port and outputs
  // ************************************************************
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              active_q, active_d;
  logic              irq_q, irq_d;

  always_comb begin
    // Zero outside the answer cycle, so an idle bus reads 00
    rdata_d = RESET_BYTE;
    if (rd_en) begin
      unique case (addr)
        ADDR_TMODE:     rdata_d = tmode_q;
        ADDR_TPRESCALE: rdata_d = tpsc_q;
        ADDR_RELOAD_HI: rdata_d = reload_q[15:8];
        ADDR_RELOAD_LO: rdata_d = reload_q[7:0];
        // Count is read live per byte; software must allow for a borrow
        ADDR_COUNT_HI:  rdata_d = cnt_q[15:8];
        ADDR_COUNT_LO:  rdata_d = cnt_q[7:0];
        ADDR_IRQ_STAT:  rdata_d = {7'h00, expired_q};
        ADDR_IRQ_MASK:  rdata_d = {7'h00, mask_q};
        ADDR_STATUS:    rdata_d = {7'h00, active_q};
        default:        rdata_d = RESET_BYTE;
      endcase
    end
    // Gate level deliberately not folded
    // Run flag follows next state, so it rises in the cycle after a start
    active_d = (state_d == ST_RUN);
    // Next-state inputs let the interrupt rise together with the flag
    irq_d    = expired_d && mask_d;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q  <= RESET_BYTE;
      active_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      active_q <= active_d;
      irq_q    <= irq_d;
    end
  end

  // Every output comes straight from a flip-flop
  assign rd_data           = rdata_q;
  assign timer_active_flag = active_q;
  assign irq               = irq_q;

endmodule // ptc_timer

// ---- include/ptc_pkg.sv ----
package ptc_pkg;

  // ************************************************************
  // Register map (byte addresses on the 8-bit register port)
  // ************************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  ADDR_TMODE      = 8'h2A;
  localparam logic [7:0]  ADDR_TPRESCALE  = 8'h2B;
  localparam logic [7:0]  ADDR_RELOAD_HI  = 8'h2C;
  localparam logic [7:0]  ADDR_RELOAD_LO  = 8'h2D;
  localparam logic [7:0]  ADDR_COUNT_HI   = 8'h2E;
  localparam logic [7:0]  ADDR_COUNT_LO   = 8'h2F;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h41;
  localparam logic [7:0]  ADDR_STATUS     = 8'h42;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h43;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          BIT_AUTO        = 7;
  localparam int          GATE_HI         = 6;
  localparam int          GATE_LO         = 5;
  localparam int          BIT_RELOAD      = 4;
  localparam int          PSC_HI_MSB      = 3;
  localparam int          BIT_EXPIRED     = 0;
  localparam int          BIT_ACTIVE      = 0;
  localparam int          BIT_START_NOW   = 0;
  localparam int          BIT_STOP_NOW    = 1;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int          PSC_W           = 12;
  localparam int          DIV_W           = 13;
  localparam int          CNT_W           = 16;
  localparam int          RXB_W           = 3;
  localparam int          NUM_GATES       = 2;
  localparam logic [2:0]  STOP_BITS_LONG  = 3'h5;
  localparam logic [2:0]  STOP_BITS_SHORT = 3'h4;
  localparam logic [15:0] CNT_ZERO        = 16'h0000;
  localparam logic [15:0] CNT_ONE         = 16'h0001;
  localparam logic [12:0] DIV_ZERO        = 13'h0000;
  localparam logic [12:0] DIV_ONE         = 13'h0001;

  typedef enum logic [1:0] {
    GATE_NONE = 2'h0,
    GATE_SSI  = 2'h1,
    GATE_AUXILIARY_PIN_ONE = 2'h2,
    GATE_RSVD = 2'h3
  } ptc_gate_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } ptc_state_t;

  // Protocol events and mode levels from the transceiver logic
  typedef struct packed {
    logic tx_end;               // Pulse: a transmission just ended
    logic rf_field_on;          // Pulse: RF field switched on
    logic inverted_tx_field_on; // Level
    logic rx_bit;               // Pulse: one received bit decoded
    logic five_bit_mode;        // Level: 14443 A or B at 106 kBd
    logic multi_frame_receive;  // Level
    logic even_prescale_select; // Level
  } ptc_proto_t;

endpackage

// ---- tb/ptc_timer_properties.sv ----
`timescale 1ns/1ps
module ptc_timer_checker
  import ptc_pkg::*;
(
  input wire logic              sys_clk,           // Clock
  input wire logic              rstn,              // Reset, active low
  input wire logic [ADDR_W-1:0] addr,              // Address
  input wire logic [DATA_W-1:0] wr_data,           // Write data
  input wire logic              wr_en,             // Write strobe
  input wire logic              rd_en,             // Read strobe
  input wire logic [DATA_W-1:0] rd_data,           // Read data
  input wire ptc_proto_t        proto,             // Protocol events
  input wire logic              timer_active_flag, // Run state
  input wire logic              irq                // Interrupt
);
  // ********
  // Shadows
  // ********
  // Settings are mirrored from bus writes, as only ports are visible here
  logic [7:0] mode_q, mode_d;
  logic       mask_q, mask_d;
  logic [2:0] rxc_q, rxc_d;
  logic       ctl_wr, start, stop_ok;
  assign ctl_wr  = wr_en && addr == ADDR_CONTROL;
  assign start   = (mode_q[BIT_AUTO] && (proto.tx_end || (proto.inverted_tx_field_on &&
                   proto.rf_field_on))) || (ctl_wr && wr_data[BIT_START_NOW]);
  assign stop_ok = mode_q[BIT_AUTO] && !proto.multi_frame_receive && timer_active_flag &&
                   proto.rx_bit && !start && !ctl_wr;
  always_comb begin
    mode_d = (wr_en && addr == ADDR_TMODE) ? wr_data : mode_q;
    mask_d = (wr_en && addr == ADDR_IRQ_MASK) ? wr_data[0] : mask_q;
    rxc_d  = start ? 3'h0 : rxc_q + {2'h0, timer_active_flag & proto.rx_bit};
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= 8'h00;
      mask_q <= 1'h0;
      rxc_q  <= 3'h0;
    end else begin
      mode_q <= mode_d;
      mask_q <= mask_d;
      rxc_q  <= rxc_d;
    end
  end
  // ********
  // Checks
  // ********
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("Read data not zero outside read cycle");
  a_tx_start: assert property (mode_q[BIT_AUTO] && proto.tx_end |=> timer_active_flag)
    else $error("No start at transmission end");
  a_field_start: assert property (mode_q[BIT_AUTO] && proto.inverted_tx_field_on &&
    proto.rf_field_on |=> timer_active_flag) else $error("No start at field on");
  a_no_proto_start: assert property (!mode_q[BIT_AUTO] && !timer_active_flag && !ctl_wr
    |=> !timer_active_flag) else $error("Start without auto mode");
  a_stop_fourth: assert property (stop_ok && !proto.five_bit_mode && rxc_q == 3'h3
    |=> !timer_active_flag) else $error("No stop after fourth bit");
  a_stop_fifth: assert property (stop_ok && proto.five_bit_mode && rxc_q == 3'h4
    |=> !timer_active_flag) else $error("No stop after fifth bit");
  a_multi_runs: assert property (mode_q[BIT_RELOAD] && proto.multi_frame_receive &&
    timer_active_flag && !ctl_wr |=> timer_active_flag) else $error("Stop in multi frame");
  a_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !irq)
    else $error("Interrupt while masked");
endmodule // ptc_timer_checker

bind ptc_timer ptc_timer_checker ptc_timer_checker_inst (.sys_clk, .rstn, .addr, .wr_data,
  .wr_en, .rd_en, .rd_data, .proto, .timer_active_flag, .irq);

// ---- tb/test_ptc_timer.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module test_ptc_timer
  import ptc_pkg::*;
;
  // ********
  // Drivers
  // ********
  localparam logic [6:0] TX = 7'h40, RF = 7'h20, INV = 7'h10, RX = 7'h08;
  localparam logic [6:0] FIVE = 7'h04, MULTI = 7'h02, EVEN = 7'h01;
  logic       sys_clk              = 1'h0;
  logic       rstn                 = 1'h0;
  logic [7:0] addr                 = 8'h00;
  logic [7:0] wr_data              = 8'h00;
  logic       wr_en                = 1'h0;
  logic       rd_en                = 1'h0;
  logic       carrier_tick         = 1'h1; // Tick every clock keeps counts exact and short
  logic       secure_serial_in_pin = 1'h0;
  logic       auxiliary_pin_one    = 1'h0;
  ptc_proto_t proto                = '0;
  logic [7:0] rd_data;
  logic       timer_active_flag;
  logic       irq;
  int         miscompares          = 0;
  int         check_count          = 0;
  always #25 sys_clk = ~sys_clk;
  ptc_timer ptc_timer_inst (.sys_clk, .rstn, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .carrier_tick, .proto, .secure_serial_in_pin, .auxiliary_pin_one, .timer_active_flag, .irq);
  // Each task leaves a free edge after its strobe, so calls may follow back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'h1;
    @(posedge sys_clk);
    wr_en   <= 1'h0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge sys_clk);
    rd_en <= 1'h0;
    #1 d = rd_data;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK("register", e, v)
  endtask
  task automatic tg(input logic [6:0] p);
    proto <= ptc_proto_t'(proto ^ p);
    @(posedge sys_clk);
  endtask
  task automatic pulse(input logic [6:0] p);
    tg(p);
    tg(p);
  endtask
  task automatic ca(input logic e);
    #1;
    `CHK("active flag", e, timer_active_flag)
  endtask
  task automatic run_len(output int n);
    n = 1;
    while (timer_active_flag === 1'h1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
      #1;
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    logic [7:0] v;
    int         n;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    for (logic [7:0] a = 8'h2A; a < 8'h44; a++) rc(a, 8'h00);
    wr(ADDR_TMODE, 8'hA5);
    wr(ADDR_TPRESCALE, 8'h5A);
    wr(8'h30, 8'h77);
    rc(ADDR_TMODE, 8'hA5);
    rc(ADDR_TPRESCALE, 8'h5A);
    rc(8'h30, 8'h00);
    wr(ADDR_TMODE, 8'h01);
    wr(ADDR_TPRESCALE, 8'h05);
    wr(ADDR_RELOAD_LO, 8'h03);
    $display("Test registers done");
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_CONTROL, 8'h01);
      run_len(n);
      `CHK("period", 3 * (2 * 'h105 + 1 + e), n)
      rc(ADDR_IRQ_STAT, 8'h01);
      rc(ADDR_COUNT_LO, 8'h00);
      #1 `CHK("irq masked", 1'h0, irq)
      wr(ADDR_IRQ_MASK, 8'h01);
      `CHK("irq", 1'h1, irq)
      wr(ADDR_IRQ_STAT, 8'h01);
      `CHK("irq cleared", 1'h0, irq)
      rc(ADDR_IRQ_STAT, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h00);
      tg(EVEN);
    end
    $display("Test prescale done");
    wr(ADDR_TMODE, 8'h10);
    wr(ADDR_TPRESCALE, 8'h00);
    wr(ADDR_CONTROL, 8'h01);
    wr(ADDR_RELOAD_LO, 8'h10);
    repeat (20) @(posedge sys_clk);
    ca(1'h1);
    rd(ADDR_COUNT_LO, v);
    `CHK("count range", 1'h1, v < 8'h04)
    wr(ADDR_CONTROL, 8'h02);
    ca(1'h0);
    wr(ADDR_TMODE, 8'h00);
    wr(ADDR_CONTROL, 8'h01);
    run_len(n);
    `CHK("new reload", 16, n)
    $display("Test reload done");
    wr(ADDR_TMODE, 8'h90);
    pulse(TX);
    ca(1'h1);
    repeat (3) pulse(RX);
    ca(1'h1);
    pulse(RX);
    ca(1'h0);
    tg(FIVE);
    pulse(TX);
    repeat (4) pulse(RX);
    ca(1'h1);
    pulse(RX);
    ca(1'h0);
    tg(FIVE ^ MULTI);
    pulse(TX);
    repeat (6) pulse(RX);
    ca(1'h1);
    wr(ADDR_CONTROL, 8'h02);
    ca(1'h0);
    tg(MULTI);
    pulse(RF);
    ca(1'h0);
    tg(INV);
    pulse(RF);
    ca(1'h1);
    tg(INV);
    wr(ADDR_CONTROL, 8'h02);
    wr(ADDR_TMODE, 8'h10);
    pulse(TX);
    ca(1'h0);
    wr(ADDR_CONTROL, 8'h01);
    repeat (5) pulse(RX);
    ca(1'h1);
    wr(ADDR_CONTROL, 8'h02);
    $display("Test protocol done");
    for (int g = 1; g < 3; g++) begin
      wr(ADDR_TMODE, {1'h0, 2'(g), 5'h00});
      secure_serial_in_pin <= (g == 2);
      auxiliary_pin_one    <= (g == 1);
      wr(ADDR_CONTROL, 8'h01);
      repeat (8) @(posedge sys_clk);
      ca(1'h1);
      rc(ADDR_COUNT_LO, 8'h10);
      secure_serial_in_pin <= 1'h1;
      auxiliary_pin_one    <= 1'h1;
      repeat (8) @(posedge sys_clk);
      rd(ADDR_COUNT_LO, v);
      `CHK("gated count", 1'h1, v < 8'h10)
      wr(ADDR_CONTROL, 8'h02);
      secure_serial_in_pin <= 1'h0;
      auxiliary_pin_one    <= 1'h0;
      // Let the pin voters settle so a stale open gate leaks no tick
      repeat (4) @(posedge sys_clk);
    end
    secure_serial_in_pin <= 1'h1;
    auxiliary_pin_one    <= 1'h1;
    wr(ADDR_TMODE, 8'h60);
    wr(ADDR_CONTROL, 8'h01);
    repeat (8) @(posedge sys_clk);
    rc(ADDR_COUNT_LO, 8'h10);
    wr(ADDR_CONTROL, 8'h02);
    $display("Test gates done");
    end_sim();
  end
  // Limit is several times the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end
endmodule // test_ptc_timer
